/* core/acl_ack_latency.sv */
// ack latency limit and ack pending timer for the receive link layer
// Notes on behaviour
// R1: payload term comes from configured payload setting
// R2: identical function settings: use the shared one
// R3: differing function settings: smallest one chosen
// R4: packet overhead is a fixed 28 symbols
// R5: internal processing delay is 19 symbols
// R6: multiplier chosen by payload size and width
// R7: limit is scaled payload over lanes plus terms
// R8: standby allowance is exit time, else zero
// R9: long synchronisation lengthens the standby allowance
// R10: measured from packet end to ack start
// R11: receiver may skip the standby adjustment
// R12: unadjusted limits match the payload/width table
// R13: effective limit is table value plus allowance
// R14: checker tolerates transmissions already in progress
// R15: checker tolerates standby exit in ack direction
// R16: timer zero when inactive, scheduled or acknowledged
// R17: timer starts only after packet is forwarded
// R18: ack due once timer reaches the limit
// R19: limit reloads on change; timer counts symbols
`timescale 1ns/1ps
module acl_ack_latency
  import acl_pkg::*;
(
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  // configuration from the function control registers
  input  wire logic [ACL_NUM_FUNC-1:0][ACL_MPS_W-1:0] i_mps_setting,
  input  wire logic [ACL_LANE_W-1:0] i_lane_count,
  input  wire logic                  i_standby_en,
  input  wire logic                  i_long_sync,
  input  wire logic [ACL_EXIT_W-1:0] i_standby_exit_sym,
  input  wire logic [ACL_EXIT_W-1:0] i_long_sync_exit_sym,
  input  wire logic                  i_adjust_en,
  // receive link layer events
  input  wire logic                  i_dl_active,
  input  wire logic                  i_pkt_forwarded,
  input  wire logic                  i_ack_nak_sched,
  input  wire logic                  i_all_acked,
  input  wire logic                  i_nak_scheduled,
  // results
  output logic [ACL_LIM_W-1:0]       o_ack_limit,
  output logic [ACL_LIM_W-1:0]       o_ack_timer,
  output logic                       o_ack_due,
  output logic                       o_mps_mixed
);

  acl_lut_if lk_if ();                  // lookup and timer carrier

  logic [ACL_MPS_W-1:0]  next_mps;      // smallest function setting
  logic                  next_mixed;    // settings differ
  logic [ACL_LANE_W-1:0] next_lanes;    // clamped lane count
  logic [ACL_EXIT_W-1:0] next_allow;    // allowance before register
  logic [ACL_MPS_W-1:0]  mps_code;      // registered payload code
  logic [ACL_LANE_W-1:0] lanes;         // registered lane count
  logic [ACL_EXIT_W-1:0] allowance;     // standby_exit_allowance
  logic [ACL_LIM_W-1:0]  base_limit;    // registered lookup result
  logic                  pending;       // forwarded, not yet acked
  logic                  due_now;       // ack due condition

  // lookup of the unadjusted limit
  acl_limit_lut u_lut (
    .lk (lk_if.lut)
  );

  // ack pending timer
  acl_ack_timer u_tmr (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .tm      (lk_if.tmr)
  );

  // pick the payload setting across functions
  // when all agree the minimum is that shared value; when they
  // differ the smallest gives the shortest limit, except 256 against 512 bytes at x5 to x8
  always_comb begin
    next_mps   = i_mps_setting[0];
    next_mixed = 1'b0;
    for (int f = 1; f < ACL_NUM_FUNC; f++) begin
      if (i_mps_setting[f] != i_mps_setting[0]) begin
        next_mixed = 1'b1;
      end
      if (i_mps_setting[f] < next_mps) begin
        next_mps = i_mps_setting[f]; // see R2, R3
      end
    end
    // reserved codes above 4096 bytes read as the largest size
    if (next_mps > ACL_MPS_MAX) begin
      next_mps = ACL_MPS_MAX;
    end
  end

  // lane count clamp: zero would divide by zero downstream
  always_comb begin
    if (i_lane_count < ACL_LANE_MIN) begin
      next_lanes = ACL_LANE_MIN;
    end else if (i_lane_count > ACL_LANE_MAX) begin
      next_lanes = ACL_LANE_MAX;
    end else begin
      next_lanes = i_lane_count;
    end
  end

  // standby exit allowance selection
  always_comb begin
    if (!i_standby_en || !i_adjust_en) begin
      next_allow = '0; // see R8, R11
    end else if (i_long_sync) begin
      next_allow = i_long_sync_exit_sym; // see R9
    end else begin
      next_allow = i_standby_exit_sym; // see R8
    end
  end

  // configuration registers, reloaded every cycle so any change
  // in setting, width or standby control reaches the limit
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mps_code    <= '0;
      lanes       <= ACL_LANE_MIN;
      allowance   <= '0;
      o_mps_mixed <= 1'b0;
    end else begin
      mps_code    <= next_mps; // see R1, R19
      lanes       <= next_lanes; // see R19
      allowance   <= next_allow; // see R19
      o_mps_mixed <= next_mixed;
    end
  end

  // drive the lookup from the registered configuration
  assign lk_if.mps_code = mps_code;
  assign lk_if.lanes    = lanes;

  // limit registers: lookup then sum, two cycles after a payload or lane register change, one after an allowance change
  // trade-off: one extra cycle of lag buys a short divider path
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      base_limit  <= ACL_LIM_RST;
      o_ack_limit <= ACL_LIM_RST;
    end else begin
      base_limit  <= lk_if.base; // see R12
      o_ack_limit <= base_limit + ACL_LIM_W'(allowance); // see R7, R13
    end
  end

  // outstanding-packet flag; a new packet wins over an ack clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pending <= 1'b0;
    end else if (!i_dl_active) begin
      pending <= 1'b0; // see R16
    end else if (i_pkt_forwarded) begin
      pending <= 1'b1; // see R17
    end else if (i_all_acked) begin
      pending <= 1'b0; // see R16
    end
  end

  // timer control: zero while inactive, on schedule, once acked
  // counting starts only after the packet has been forwarded,
  // so the first count marks the packet end at this port
  assign lk_if.clr = !i_dl_active || i_ack_nak_sched ||
                     (i_all_acked && !i_pkt_forwarded); // see R16
  assign lk_if.run = pending; // see R10, R17
  assign o_ack_timer = lk_if.count;

  // ack due when the limit is reached; a nak in flight suppresses
  assign due_now = i_dl_active && pending && !i_nak_scheduled &&
                   !i_ack_nak_sched &&
                   (lk_if.count >= o_ack_limit); // see R18

  // registered request to the ack scheduler
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ack_due <= 1'b0;
    end else begin
      o_ack_due <= due_now; // see R18
    end
  end

  // timer is zero the cycle after the link layer goes inactive
  a_timer_inactive: assert property ( // see R16
    @(posedge i_clk) disable iff (!i_rst_b)
    !i_dl_active |=> o_ack_timer == '0)
    else $error("ack timer not cleared while inactive");

  // scheduling an ack or nak restarts the timer from zero
  a_timer_restart: assert property ( // see R16
    @(posedge i_clk) disable iff (!i_rst_b)
    i_ack_nak_sched |=> o_ack_timer == '0)
    else $error("ack timer not restarted on schedule");

  // no count before the first packet is forwarded
  a_timer_start: assert property ( // see R17
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(pending) |-> o_ack_timer == '0)
    else $error("ack timer ran before forward");

  // timer advances by exactly one per symbol while pending
  a_timer_step: assert property ( // see R19
    @(posedge i_clk) disable iff (!i_rst_b)
    (pending && !lk_if.clr && o_ack_timer != ACL_TMR_SAT)
      |=> o_ack_timer == $past(o_ack_timer) + 14'h0001)
    else $error("ack timer step wrong");

  // reaching the limit raises the due request next cycle
  a_due_limit: assert property ( // see R18
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_dl_active && pending && !i_nak_scheduled && !i_ack_nak_sched
      && o_ack_timer >= o_ack_limit) |=> o_ack_due)
    else $error("ack due missed at limit");

  // due never raised below the limit
  a_due_cause: assert property ( // see R18
    @(posedge i_clk) disable iff (!i_rst_b)
    o_ack_due |-> $past(o_ack_timer) >= $past(o_ack_limit))
    else $error("ack due raised below limit");

  // standby disabled gives a zero allowance
  a_allow_zero: assert property ( // see R8
    @(posedge i_clk) disable iff (!i_rst_b)
    !i_standby_en |=> allowance == '0)
    else $error("allowance nonzero with standby off");

  // long synchronisation picks the lengthened exit time
  a_allow_long: assert property ( // see R9
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_standby_en && i_adjust_en && i_long_sync)
      |=> allowance == $past(i_long_sync_exit_sym))
    else $error("long sync exit time not used");

  // effective limit is lookup value plus allowance
  a_limit_sum: assert property ( // see R13
    @(posedge i_clk) disable iff (!i_rst_b)
    ##1 o_ack_limit == $past(base_limit) + ACL_LIM_W'($past(allowance)))
    else $error("limit is not base plus allowance");

  // known table point: 128 bytes at one lane
  a_table_point: assert property ( // see R12
    @(posedge i_clk) disable iff (!i_rst_b)
    (mps_code == '0 && lanes == ACL_LANE_MIN)
      |=> base_limit == ACL_LIM_128_X1)
    else $error("128 byte x1 limit wrong");

  // smallest function setting selected
  a_mps_min: assert property ( // see R3
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_mps_setting[0] <= ACL_MPS_MAX && i_mps_setting[1] <= ACL_MPS_MAX)
      |=> mps_code <= $past(i_mps_setting[0]) &&
          mps_code <= $past(i_mps_setting[1]))
    else $error("payload setting not the smallest");

endmodule // acl_ack_latency

/* include/acl_pkg.sv */
// constants and widths shared by the ack latency limit logic
package acl_pkg;
  // structure widths
  localparam int ACL_NUM_FUNC = 2;
  localparam int ACL_MPS_W    = 3;
  localparam int ACL_LANE_W   = 6;
  localparam int ACL_LIM_W    = 14;
  localparam int ACL_EXIT_W   = 12;
  localparam int ACL_NUM_W    = 17;
  localparam int ACL_DEN_W    = 9;
  // formula constants, in symbol times
  localparam logic [ACL_NUM_W-1:0] ACL_OVERHEAD_SYM  = 17'h0_001C;
  localparam logic [ACL_LIM_W-1:0] ACL_INT_DELAY_SYM = 14'h0013;
  // payload setting code 0 means 128 bytes, each step doubles
  localparam logic [ACL_NUM_W-1:0] ACL_MPS_BASE = 17'h0_0080;
  localparam logic [ACL_MPS_W-1:0] ACL_MPS_MAX  = 3'h5;
  localparam logic [ACL_MPS_W-1:0] ACL_MPS_SMALL_TOP = 3'h1;
  // ack multipliers, scaled by ten
  localparam logic [4:0] ACL_AF_1P4 = 5'h0E;
  localparam logic [4:0] ACL_AF_2P5 = 5'h19;
  localparam logic [4:0] ACL_AF_3P0 = 5'h1E;
  localparam logic [4:0] ACL_AF_1P0 = 5'h0A;
  localparam logic [4:0] ACL_AF_2P0 = 5'h14;
  localparam logic [3:0] ACL_AF_SCALE = 4'hA;
  // lane count breakpoints
  localparam logic [ACL_LANE_W-1:0] ACL_LANE_MIN = 6'h01;
  localparam logic [ACL_LANE_W-1:0] ACL_LANE_X4  = 6'h04;
  localparam logic [ACL_LANE_W-1:0] ACL_LANE_X8  = 6'h08;
  localparam logic [ACL_LANE_W-1:0] ACL_LANE_MAX = 6'h20;
  // reset and saturation values
  localparam logic [ACL_LIM_W-1:0] ACL_LIM_RST  = 14'h102F;
  localparam logic [ACL_LIM_W-1:0] ACL_TMR_SAT  = 14'h3FFF;
  // known point of the unadjusted limit: 128 bytes at x1
  localparam logic [ACL_LIM_W-1:0] ACL_LIM_128_X1 = 14'h00ED;
endpackage

/* include/acl_lut_if.sv */
// carrier between the top and its lookup and timer modules
`timescale 1ns/1ps
interface acl_lut_if;
  import acl_pkg::*;
  logic [ACL_MPS_W-1:0]  mps_code; // selected payload setting
  logic [ACL_LANE_W-1:0] lanes;    // clamped lane count
  logic [ACL_LIM_W-1:0]  base;     // unadjusted limit
  logic                  clr;      // timer clear
  logic                  run;      // timer advance
  logic [ACL_LIM_W-1:0]  count;    // timer value
  modport core (output mps_code, lanes, clr, run, input base, count);
  modport lut  (input mps_code, lanes, output base);
  modport tmr  (input clr, run, output count);
endinterface // acl_lut_if

/* core/acl_limit_lut.sv */
// unadjusted ack latency limit from payload setting and lane count
`timescale 1ns/1ps
module acl_limit_lut
  import acl_pkg::*;
(
  // lookup port
  acl_lut_if.lut lk
);
  logic [ACL_NUM_W-1:0] bytes; // payload in bytes
  logic [4:0]           af;    // multiplier times ten
  logic [ACL_NUM_W-1:0] num;   // scaled dividend
  logic [ACL_DEN_W-1:0] den;   // lanes times ten
  logic [ACL_NUM_W-1:0] quo;   // floor of the quotient

  // formula floors, which reproduces every table entry
  always_comb begin
    bytes = ACL_MPS_BASE << lk.mps_code;
    if (lk.mps_code <= ACL_MPS_SMALL_TOP) begin
      if (lk.lanes <= ACL_LANE_X4) af = ACL_AF_1P4;
      else if (lk.lanes <= ACL_LANE_X8) af = ACL_AF_2P5;
      else af = ACL_AF_3P0;
    end else begin
      if (lk.lanes <= ACL_LANE_X8) af = ACL_AF_1P0;
      else af = ACL_AF_2P0;
    end
    num = ACL_NUM_W'((bytes + ACL_OVERHEAD_SYM) * af); // see R4, R6
    // widen before the product: 32 lanes times ten needs nine bits
    den = ACL_DEN_W'(lk.lanes) * ACL_DEN_W'(ACL_AF_SCALE);
    quo = num / ACL_NUM_W'(den); // see R7
    lk.base = ACL_LIM_W'(quo) + ACL_INT_DELAY_SYM; // see R5, R12
  end
endmodule // acl_limit_lut

/* core/acl_ack_timer.sv */
// ack pending timer, one count per symbol time
`timescale 1ns/1ps
module acl_ack_timer
  import acl_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // control and count
  acl_lut_if.tmr    tm
);
  // clear beats advance; saturate rather than wrap
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tm.count <= '0;
    end else if (tm.clr) begin
      tm.count <= '0; // see R16
    end else if (tm.run && tm.count != ACL_TMR_SAT) begin
      tm.count <= tm.count + 14'h0001; // see R19
    end
  end
endmodule // acl_ack_timer

/* sim/acl_partner_model.sv */
// far side model: link partner that sends packets and takes acks
`timescale 1ns/1ps
module acl_partner_model #(
  parameter int ACK_HOLD = 3  // cycles of a transfer already on the wire
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // requests from the bench and the block
  input  wire logic i_send,
  input  wire logic i_ack_due,
  // standby exit time of the ack direction, zero when awake
  input  wire logic [11:0] i_exit_sym,
  // toward the block
  output logic      o_fwd,
  output logic      o_ack_sched,
  output logic      o_all_acked
);
  int unsigned pend;  // packets not yet acknowledged
  int unsigned hold;  // busy cycles spent before the ack leaves
  // ack goes out late: a transfer in flight delays it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend        <= 0;
      hold        <= 0;
      o_fwd       <= 1'b0;
      o_ack_sched <= 1'b0;
    end else begin
      o_fwd       <= i_send;
      o_ack_sched <= 1'b0;
      if (i_send)
        pend <= pend + 1;
      // guard: due is still up during the cycle of the ack pulse
      if (i_ack_due && !o_ack_sched) begin
        if (hold == ACK_HOLD + i_exit_sym) begin
          o_ack_sched <= 1'b1;
          hold        <= 0;
          pend        <= i_send ? 1 : 0;
        end else begin
          hold <= hold + 1;
        end
      end
    end
  end
  // nothing left unacknowledged
  assign o_all_acked = (pend == 0);
endmodule // acl_partner_model

/* sim/tb_top.sv */
// self-checking bench for the ack latency limit block
`timescale 1ns/1ps
module tb_top;
  import acl_pkg::*;
  logic i_clk = 1'b0;   // 40 MHz symbol clock
  logic i_rst_b = 1'b0; // active low reset
  logic [ACL_NUM_FUNC-1:0][ACL_MPS_W-1:0] mps = '0; // per function code
  logic [ACL_LANE_W-1:0] lanes = 6'h01;             // operating lanes
  logic sb_en = 1'b0, l_sync = 1'b0, adj = 1'b0;    // standby controls
  logic dl = 1'b0, nak = 1'b0, send = 1'b0;         // link state
  logic [ACL_EXIT_W-1:0] ex_sb = 12'h064, ex_ls = 12'h12C; // exit times
  logic fwd, sched, acked, due, mixed;              // handshake lines
  logic [ACL_LIM_W-1:0] lim, tmr;                   // results
  int n_errors = 0;
  int samples_checked = 0;
  int wl[7] = '{1, 2, 4, 8, 12, 16, 32};            // table widths
  always #12.5 i_clk = ~i_clk;

  acl_ack_latency i_acl_ack_latency (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_mps_setting(mps), .i_lane_count(lanes), .i_standby_en(sb_en),
    .i_long_sync(l_sync), .i_standby_exit_sym(ex_sb),
    .i_long_sync_exit_sym(ex_ls), .i_adjust_en(adj), .i_dl_active(dl),
    .i_pkt_forwarded(fwd), .i_ack_nak_sched(sched), .i_all_acked(acked),
    .i_nak_scheduled(nak), .o_ack_limit(lim), .o_ack_timer(tmr),
    .o_ack_due(due), .o_mps_mixed(mixed));
  acl_partner_model i_acl_partner_model (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_send(send), .i_ack_due(due), .o_fwd(fwd), .o_ack_sched(sched),
    .o_all_acked(acked),
    .i_exit_sym(sb_en ? (l_sync ? ex_ls : ex_sb) : 12'h000));

  // limit worked out from payload, overhead, multiplier and lanes
  function automatic logic [ACL_LIM_W-1:0] exp_lim(input int c, w);
    int af;
    af = (c <= 1) ? ((w <= 4) ? 14 : (w <= 8) ? 25 : 30)
                  : ((w <= 8) ? 10 : 20);
    return 14'(((128 << c) + 28) * af / (10 * w) + 19);
  endfunction
  task automatic chk_val(input logic [ACL_LIM_W-1:0] got, exp,
                         input string m);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %b", $time, m, got);
    end
  endtask
  // settings land three edges later, one spare
  task automatic cfg(input int c0, c1, w);
    mps[0] = c0[2:0];
    mps[1] = c1[2:0];
    lanes = w[5:0];
    repeat (4) @(negedge i_clk);
  endtask
  task automatic pulse;
    send = 1'b1;
    @(negedge i_clk);
    send = 1'b0;
  endtask
  task automatic wait_clear;
    for (int i = 0; i < 20 && tmr !== '0; i++) @(negedge i_clk);
  endtask
  task automatic t_table;
    for (int c = 0; c < 6; c++)
      for (int k = 0; k < 7; k++) begin
        cfg(c, c, wl[k]);
        chk_val(lim, exp_lim(c, wl[k]), "table");
      end
    cfg(0, 0, 1);
    chk_val(lim, 14'h00ED, "128 x1");
    cfg(5, 5, 1);
    chk_val(lim, 14'h102F, "4096 x1");
    cfg(0, 0, 32);
    chk_val(lim, 14'h0021, "128 x32");
    cfg(7, 7, 0);
    chk_val(lim, exp_lim(5, 1), "clamp low");
    cfg(0, 0, 40);
    chk_val(lim, exp_lim(0, 32), "clamp high");
    $display("test table done");
  endtask
  task automatic t_multi;
    cfg(2, 2, 4);
    chk_bit(mixed, 1'b0, "same mixed");
    chk_val(lim, exp_lim(2, 4), "shared");
    cfg(4, 0, 8);
    chk_bit(mixed, 1'b1, "diff mixed");
    chk_val(lim, exp_lim(0, 8), "smallest");
    $display("test multi done");
  endtask
  task automatic t_standby;
    cfg(0, 0, 1);
    adj = 1'b1;
    sb_en = 1'b1;
    repeat (4) @(negedge i_clk);
    chk_val(lim, exp_lim(0, 1) + 14'h0064, "standby");
    l_sync = 1'b1;
    repeat (4) @(negedge i_clk);
    chk_val(lim, exp_lim(0, 1) + 14'h012C, "long sync");
    sb_en = 1'b0;
    repeat (4) @(negedge i_clk);
    chk_val(lim, exp_lim(0, 1), "standby off");
    sb_en = 1'b1;
    adj = 1'b0;
    repeat (4) @(negedge i_clk);
    chk_val(lim, exp_lim(0, 1), "no adjust");
    sb_en = 1'b0;
    l_sync = 1'b0;
    $display("test standby done");
  endtask
  task automatic t_timer;
    cfg(0, 0, 32);
    dl = 1'b1;
    repeat (2) @(negedge i_clk);
    chk_val(tmr, 14'h0000, "idle timer");
    pulse;
    for (int i = 0; i < 100 && due !== 1'b1; i++) @(negedge i_clk);
    chk_val(tmr, 14'h0022, "due point");
    wait_clear;
    chk_bit(due, 1'b0, "due after ack");
    chk_val(tmr, 14'h0000, "timer after ack");
    sb_en = 1'b1;
    pulse;
    for (int i = 0; i < 100 && due !== 1'b1; i++) @(negedge i_clk);
    repeat (60) @(negedge i_clk);
    chk_bit(due, 1'b1, "due held in exit");
    for (int i = 0; i < 100 && tmr !== '0; i++) @(negedge i_clk);
    chk_val(tmr, 14'h0000, "ack after exit");
    sb_en = 1'b0;
    nak = 1'b1;
    pulse;
    repeat (45) @(negedge i_clk);
    chk_bit(due, 1'b0, "nak holds");
    chk_bit(tmr > lim, 1'b1, "counted past");
    nak = 1'b0;
    @(negedge i_clk);
    chk_bit(due, 1'b1, "due after nak");
    wait_clear;
    pulse;
    repeat (10) @(negedge i_clk);
    chk_bit(tmr != '0, 1'b1, "counting");
    dl = 1'b0;
    repeat (2) @(negedge i_clk);
    chk_val(tmr, 14'h0000, "inactive");
    pulse;
    repeat (4) @(negedge i_clk);
    chk_val(tmr, 14'h0000, "ignored fwd");
    $display("test timer done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    test_done;
  end
  // main sequence
  initial begin
    repeat (8) @(negedge i_clk);
    chk_val(lim, 14'h102F, "reset limit");
    chk_val(tmr, 14'h0000, "reset timer");
    chk_bit(due, 1'b0, "reset due");
    i_rst_b = 1'b1;
    @(negedge i_clk);
    t_table;
    t_multi;
    t_standby;
    t_timer;
    test_done;
  end
endmodule // tb_top
